//--- pkg/vei_defines.vh
// constants for the virtual event injection block
`ifndef VEI_DEFINES_VH
`define VEI_DEFINES_VH

// ----------------------------------------------------------------
// event inject descriptor field layout
// ----------------------------------------------------------------
`define VEI_DESC_VEC_MSB 7
`define VEI_DESC_VEC_LSB 0
`define VEI_DESC_TYPE_MSB 10
`define VEI_DESC_TYPE_LSB 8
`define VEI_DESC_ERRV_BIT 11
`define VEI_DESC_VALID_BIT 31
`define VEI_DESC_ERR_MSB 63
`define VEI_DESC_ERR_LSB 32
`define VEI_DESC_RESET 64'h0000000000000000

// ----------------------------------------------------------------
// event type encodings
// ----------------------------------------------------------------
`define VEI_TYPE_EXT_IRQ 3'h0
`define VEI_TYPE_NMI 3'h2
`define VEI_TYPE_EXCEPTION 3'h3
`define VEI_TYPE_SOFT_IRQ 3'h4

// ----------------------------------------------------------------
// vector limits
// ----------------------------------------------------------------
`define VEI_VEC_NMI 8'h02
`define VEI_VEC_EXC_LIMIT 8'h20
`define VEI_VEC_BOUND 8'h05

// ----------------------------------------------------------------
// guest exit codes
// ----------------------------------------------------------------
`define VEI_EXIT_NONE 8'h00
`define VEI_EXIT_INVALID 8'hFF
`define VEI_EXIT_HCALL 8'h81
`define VEI_EXIT_VIRQ_WIN 8'h64
`define VEI_EXIT_EXC 8'h40
`define VEI_EXIT_HOST 8'h7F

// ----------------------------------------------------------------
// control register indices
// ----------------------------------------------------------------
`define VEI_CR_ZERO 4'h0
`define VEI_CR_PRIO 4'h8
`define VEI_TPR_RESET 4'h0

`endif

//--- rtl/vei_desc_check.v
// descriptor decode and entry legality checks
`timescale 1ns/1ps
`include "vei_defines.vh"

module vei_desc_check (
    input wire [63:0] desc_in,
    input wire long_mode_in,
    output wire inject_out,
    output wire invalid_out,
    output wire [7:0] vector_out,
    output wire [2:0] type_out,
    output wire push_err_out,
    output wire [31:0] err_word_out
);
    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    wire valid_bit = desc_in[`VEI_DESC_VALID_BIT];
    wire [2:0] ev_type = desc_in[`VEI_DESC_TYPE_MSB:`VEI_DESC_TYPE_LSB];
    wire [7:0] ev_vec = desc_in[`VEI_DESC_VEC_MSB:`VEI_DESC_VEC_LSB];
    wire type_reserved = (ev_type != `VEI_TYPE_EXT_IRQ) && (ev_type != `VEI_TYPE_NMI) &&
                         (ev_type != `VEI_TYPE_EXCEPTION) && (ev_type != `VEI_TYPE_SOFT_IRQ);
    wire is_exc = (ev_type == `VEI_TYPE_EXCEPTION);
    wire bad_exc_vec = is_exc && ((ev_vec >= `VEI_VEC_EXC_LIMIT) || (ev_vec == `VEI_VEC_NMI));
    wire impossible = is_exc && long_mode_in && (ev_vec == `VEI_VEC_BOUND);

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign invalid_out = valid_bit && (type_reserved || bad_exc_vec || impossible);
    assign inject_out = valid_bit && !invalid_out;
    assign vector_out = (ev_type == `VEI_TYPE_NMI) ? 8'h00 : ev_vec;
    assign type_out = ev_type;
    assign push_err_out = desc_in[`VEI_DESC_ERRV_BIT];
    assign err_word_out = desc_in[`VEI_DESC_ERRV_BIT] ?
                          desc_in[`VEI_DESC_ERR_MSB:`VEI_DESC_ERR_LSB] : 32'h00000000;
endmodule // vei_desc_check

//--- rtl/vei_core.v
// guest event injection and virtual interrupt control
`timescale 1ns/1ps
`include "vei_defines.vh"

// Function
// - uncaught hypervisor call in guest raises undefined-opcode fault
// - entry accepts protection off with paging on as paged real mode
// - valid injected event is taken before the first guest instruction
// - injected event skips intercepts; secondary exceptions still checked
// - event impossible in guest mode makes entry exit with invalid code
// - low eight bits hold vector, ignored for type two
// - three-bit type: 0 irq, 2 nmi, 3 exception, 4 software irq
// - error-valid bit pushes upper 32-bit error word, else ignored
// - inject only when descriptor valid bit is one
// - reserved type or bad exception vector gives invalid entry code
// - mask mode picks host or guest enable flag for physical irqs
// - physical priority gates physical, virtual priority gates virtual
// - mask mode clear: priority writes in guest update both, in host physical only; reads physical
// - mask mode set: writes update virtual only, reads return virtual
// - locked move to control register zero accesses priority register
// - virtual irq needs priority, enable, gate open, no shadow; physical wins
// - virtual vector comes from loaded register, no fetch cycle
// - priority bypass skips the virtual priority comparison
// - pending flag cleared after intercept check, before table read
// - exit writes pending back, then clears pending and mask mode
// - interrupt shadow saved at exit, restored at entry
// - window intercept exits just before a virtual irq is taken
// - global gate set and clear instructions control event taking
module vei_core (
    input wire clk_in,
    input wire sys_rst_in,
    // guest entry with control block fields
    input wire entry_in,
    input wire [63:0] event_inject_descriptor_in,
    input wire protection_on_in,
    input wire paging_on_in,
    input wire long_mode_in,
    input wire virt_irq_mask_mode_in,
    input wire [3:0] virt_task_priority_in,
    input wire virt_irq_pending_in,
    input wire [3:0] virt_irq_priority_in,
    input wire [7:0] virt_irq_vector_num_in,
    input wire virt_priority_bypass_in,
    input wire shadow_in,
    input wire virt_irq_window_in,
    input wire hcall_intercept_in,
    input wire host_irq_enable_in,
    // guest execution events
    input wire boundary_in,
    input wire irq_enable_flag_in,
    input wire set_irq_enable_insn_in,
    input wire hypervisor_call_insn_in,
    input wire sec_exc_in,
    input wire sec_exc_intercept_in,
    input wire host_exit_in,
    input wire gate_set_in,
    input wire gate_clr_in,
    input wire phys_irq_pending_in,
    input wire [3:0] phys_irq_priority_in,
    // control register moves
    input wire cr_wr_in,
    input wire cr_rd_in,
    input wire cr_lock_in,
    input wire [3:0] cr_index_in,
    input wire [3:0] cr_wdata_in,
    // outputs
    output reg guest_active_out,
    output reg paged_real_out,
    output reg inject_out,
    output reg [7:0] inject_vector_out,
    output reg [2:0] inject_type_out,
    output reg inject_push_err_out,
    output reg [31:0] inject_err_out,
    output reg bypass_intercept_out,
    output reg undefined_opcode_fault_out,
    output reg guest_exit_out,
    output reg [7:0] exit_code_out,
    output reg wb_pending_out,
    output reg [3:0] wb_virt_task_priority_out,
    output reg wb_shadow_out,
    output reg phys_irq_take_out,
    output reg virt_irq_take_out,
    output reg [7:0] virt_irq_vector_out,
    output reg [3:0] phys_task_priority_out,
    output reg [3:0] prio_rdata_out,
    output reg prio_rvalid_out,
    output reg global_irq_gate_out
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [1:0] ST_HOST = 2'h0;
    localparam [1:0] ST_INJECT = 2'h1;
    localparam [1:0] ST_GUEST = 2'h2;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // locked move to register zero aliases the priority register
    function is_prio_access;
        input [3:0] idx;
        input lock;
        begin
            is_prio_access = (idx == `VEI_CR_PRIO) || (lock && (idx == `VEI_CR_ZERO));
        end
    endfunction

    // strict priority comparison shared by both interrupt kinds
    function prio_above;
        input [3:0] req;
        input [3:0] thr;
        begin
            prio_above = (req > thr);
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg mask_mode_q;
    reg host_if_q;
    reg vpend_q;
    reg [3:0] vprio_q;
    reg [7:0] vvec_q;
    reg vbypass_q;
    reg vwin_q;
    reg hcall_int_q;
    reg shadow_q;
    reg [3:0] vtpr_q;

    wire chk_inject;
    wire chk_invalid;
    wire [7:0] chk_vec;
    wire [2:0] chk_type;
    wire chk_push;
    wire [31:0] chk_err;

    // ----------------------------------------------------------------
    // descriptor checks
    // ----------------------------------------------------------------
    vei_desc_check u_check (
        .desc_in(event_inject_descriptor_in),
        .long_mode_in(long_mode_in),
        .inject_out(chk_inject),
        .invalid_out(chk_invalid),
        .vector_out(chk_vec),
        .type_out(chk_type),
        .push_err_out(chk_push),
        .err_word_out(chk_err)
    );

    // ----------------------------------------------------------------
    // interrupt arbitration
    // ----------------------------------------------------------------
    wire in_guest = (state_q == ST_GUEST);
    wire phys_if = mask_mode_q ? host_if_q : irq_enable_flag_in;
    wire phys_ok = in_guest && boundary_in && phys_irq_pending_in && global_irq_gate_out && phys_if &&
                   prio_above(phys_irq_priority_in, phys_task_priority_out) && !shadow_q;
    wire virt_prio_ok = vbypass_q || prio_above(vprio_q, vtpr_q);
    wire virt_ok = in_guest && boundary_in && vpend_q && irq_enable_flag_in && global_irq_gate_out &&
                   !shadow_q && virt_prio_ok && !phys_ok;
    wire win_exit = virt_ok && vwin_q;
    wire hcall_exit = in_guest && hypervisor_call_insn_in && hcall_int_q;
    wire exc_exit = (state_q != ST_HOST) && sec_exc_in && sec_exc_intercept_in;
    wire any_exit = (state_q != ST_HOST) && (host_exit_in || win_exit || hcall_exit || exc_exit);
    wire prio_wr = cr_wr_in && is_prio_access(cr_index_in, cr_lock_in);
    wire prio_rd = cr_rd_in && is_prio_access(cr_index_in, cr_lock_in);
    wire virt_ctl = mask_mode_q && (state_q != ST_HOST);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_HOST: begin
                if (entry_in && !chk_invalid) begin
                    state_d = chk_inject ? ST_INJECT : ST_GUEST;
                end
            end
            ST_INJECT: begin
                state_d = any_exit ? ST_HOST : ST_GUEST;
            end
            ST_GUEST: begin
                if (any_exit) begin
                    state_d = ST_HOST;
                end
            end
            default: begin
                state_d = ST_HOST;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_HOST;
            mask_mode_q <= 1'b0;
            host_if_q <= 1'b0;
            vpend_q <= 1'b0;
            vprio_q <= 4'h0;
            vvec_q <= 8'h00;
            vbypass_q <= 1'b0;
            vwin_q <= 1'b0;
            hcall_int_q <= 1'b0;
            shadow_q <= 1'b0;
            vtpr_q <= `VEI_TPR_RESET;
        end else begin
            state_q <= state_d;
            if (state_q == ST_HOST && entry_in && !chk_invalid) begin
                mask_mode_q <= virt_irq_mask_mode_in;
                host_if_q <= host_irq_enable_in;
                vpend_q <= virt_irq_pending_in;
                vprio_q <= virt_irq_priority_in;
                vvec_q <= virt_irq_vector_num_in;
                vbypass_q <= virt_priority_bypass_in;
                vwin_q <= virt_irq_window_in;
                hcall_int_q <= hcall_intercept_in;
                shadow_q <= shadow_in;
                vtpr_q <= virt_task_priority_in;
            end else if (any_exit) begin
                vpend_q <= 1'b0;
                mask_mode_q <= 1'b0;
                shadow_q <= 1'b0;
            end else begin
                if (virt_ok && !vwin_q) begin
                    vpend_q <= 1'b0;
                end
                if (in_guest && set_irq_enable_insn_in && !irq_enable_flag_in) begin
                    shadow_q <= 1'b1;
                end else if (in_guest && boundary_in) begin
                    shadow_q <= 1'b0;
                end
                if (prio_wr && (state_q != ST_HOST)) begin
                    vtpr_q <= cr_wdata_in;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // global gate and physical priority
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            global_irq_gate_out <= 1'b1;
            phys_task_priority_out <= `VEI_TPR_RESET;
            prio_rdata_out <= 4'h0;
            prio_rvalid_out <= 1'b0;
        end else begin
            if (gate_set_in) begin
                global_irq_gate_out <= 1'b1;
            end else if (gate_clr_in) begin
                global_irq_gate_out <= 1'b0;
            end
            if (prio_wr && !virt_ctl) begin
                phys_task_priority_out <= cr_wdata_in;
            end
            prio_rvalid_out <= prio_rd;
            prio_rdata_out <= virt_ctl ? vtpr_q : phys_task_priority_out;
        end
    end

    // ----------------------------------------------------------------
    // interrupt take outputs
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phys_irq_take_out <= 1'b0;
            virt_irq_take_out <= 1'b0;
            virt_irq_vector_out <= 8'h00;
        end else begin
            phys_irq_take_out <= phys_ok;
            virt_irq_take_out <= virt_ok && !vwin_q && !any_exit;
            if (virt_ok) begin
                virt_irq_vector_out <= vvec_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // entry, injection and exit outputs
    // ----------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            guest_active_out <= 1'b0;
            paged_real_out <= 1'b0;
            inject_out <= 1'b0;
            inject_vector_out <= 8'h00;
            inject_type_out <= 3'h0;
            inject_push_err_out <= 1'b0;
            inject_err_out <= 32'h00000000;
            bypass_intercept_out <= 1'b0;
            undefined_opcode_fault_out <= 1'b0;
            guest_exit_out <= 1'b0;
            exit_code_out <= `VEI_EXIT_NONE;
            wb_pending_out <= 1'b0;
            wb_virt_task_priority_out <= `VEI_TPR_RESET;
            wb_shadow_out <= 1'b0;
        end else begin
            guest_active_out <= (state_d != ST_HOST);
            inject_out <= 1'b0;
            bypass_intercept_out <= 1'b0;
            undefined_opcode_fault_out <= 1'b0;
            guest_exit_out <= 1'b0;
            if (state_q == ST_HOST && entry_in) begin
                paged_real_out <= !protection_on_in && paging_on_in;
                if (chk_invalid) begin
                    guest_exit_out <= 1'b1;
                    exit_code_out <= `VEI_EXIT_INVALID;
                    wb_pending_out <= virt_irq_pending_in;
                    wb_virt_task_priority_out <= virt_task_priority_in;
                    wb_shadow_out <= shadow_in;
                end else if (chk_inject) begin
                    inject_out <= 1'b1;
                    bypass_intercept_out <= 1'b1;
                    inject_vector_out <= chk_vec;
                    inject_type_out <= chk_type;
                    inject_push_err_out <= chk_push;
                    inject_err_out <= chk_err;
                end
            end
            if (in_guest && hypervisor_call_insn_in && !hcall_int_q) begin
                undefined_opcode_fault_out <= 1'b1;
            end
            if (any_exit) begin
                guest_exit_out <= 1'b1;
                paged_real_out <= 1'b0;
                wb_pending_out <= vpend_q;
                wb_virt_task_priority_out <= vtpr_q;
                wb_shadow_out <= shadow_q;
                if (hcall_exit) begin
                    exit_code_out <= `VEI_EXIT_HCALL;
                end else if (exc_exit) begin
                    exit_code_out <= `VEI_EXIT_EXC;
                end else if (win_exit) begin
                    exit_code_out <= `VEI_EXIT_VIRQ_WIN;
                end else begin
                    exit_code_out <= `VEI_EXIT_HOST;
                end
            end
        end
    end
endmodule // vei_core

//--- tb/vei_core_checker.sv
// concurrent checks on the virtual event injection core ports
`timescale 1ns/1ps
`include "vei_defines.vh"

module vei_core_checker (
    input wire clk_in,
    input wire sys_rst_in,
    input wire entry_in,
    input wire [63:0] event_inject_descriptor_in,
    input wire hypervisor_call_insn_in,
    input wire hcall_intercept_in,
    input wire host_exit_in,
    input wire boundary_in,
    input wire gate_set_in,
    input wire gate_clr_in,
    input wire guest_active_out,
    input wire inject_out,
    input wire [7:0] inject_vector_out,
    input wire [2:0] inject_type_out,
    input wire bypass_intercept_out,
    input wire undefined_opcode_fault_out,
    input wire guest_exit_out,
    input wire [7:0] exit_code_out,
    input wire phys_irq_take_out,
    input wire virt_irq_take_out,
    input wire global_irq_gate_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire ent = entry_in && !guest_active_out;
    wire vb = event_inject_descriptor_in[31];
    wire [2:0] ty = event_inject_descriptor_in[10:8];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_inj;
        ent && vb && ty == 3'h0 |=> inject_out && bypass_intercept_out && guest_active_out;
    endproperty
    a_inj: assert property (p_inj) else $error("no inject after valid entry");
    property p_noinj;
        ent && !vb |=> !inject_out && !guest_exit_out;
    endproperty
    a_noinj: assert property (p_noinj) else $error("inject without valid bit");
    property p_rsv;
        ent && vb && (ty == 3'h1 || ty >= 3'h5)
            |=> guest_exit_out && exit_code_out == `VEI_EXIT_INVALID && !inject_out;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved type not refused");
    property p_nmi;
        inject_out && inject_type_out == 3'h2 |-> inject_vector_out == 8'h00;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi vector not ignored");
    property p_ud;
        guest_active_out && !inject_out && hypervisor_call_insn_in && !hcall_intercept_in
            |=> undefined_opcode_fault_out && !guest_exit_out;
    endproperty
    a_ud: assert property (p_ud) else $error("missing undefined opcode fault");
    property p_excl;
        !(phys_irq_take_out && virt_irq_take_out);
    endproperty
    a_excl: assert property (p_excl) else $error("both irq kinds taken");
    property p_gate;
        gate_clr_in && !gate_set_in ##1 1'b1 |-> !global_irq_gate_out;
    endproperty
    a_gate: assert property (p_gate) else $error("gate not closed");
    property p_gateblk;
        boundary_in && !global_irq_gate_out |-> ##1 !virt_irq_take_out && !phys_irq_take_out;
    endproperty
    a_gateblk: assert property (p_gateblk) else $error("irq taken with gate closed");
    property p_exit;
        guest_active_out && host_exit_in |=> guest_exit_out && exit_code_out == `VEI_EXIT_HOST && !guest_active_out;
    endproperty
    a_exit: assert property (p_exit) else $error("host exit not honoured");

    c_inj: cover property (inject_out);
    c_virt: cover property (virt_irq_take_out);
    c_ud: cover property (undefined_opcode_fault_out);
endmodule // vei_core_checker

bind vei_core vei_core_checker chk (.*);

//--- tb/virtual_event_injection_bench.sv
// self-checking bench for the virtual event injection core
`timescale 1ns/1ps
`include "vei_defines.vh"

module virtual_event_injection_bench;
    logic clk_in, sys_rst_in;
    bit entry_in, protection_on_in, paging_on_in, long_mode_in, virt_irq_mask_mode_in, virt_irq_pending_in;
    bit virt_priority_bypass_in, shadow_in, virt_irq_window_in, hcall_intercept_in, host_irq_enable_in;
    bit boundary_in, irq_enable_flag_in, set_irq_enable_insn_in, hypervisor_call_insn_in, sec_exc_in;
    bit sec_exc_intercept_in, host_exit_in, gate_set_in, gate_clr_in, phys_irq_pending_in;
    bit cr_wr_in, cr_rd_in, cr_lock_in;
    bit [63:0] event_inject_descriptor_in;
    bit [3:0] virt_task_priority_in, virt_irq_priority_in, phys_irq_priority_in, cr_index_in, cr_wdata_in;
    bit [7:0] virt_irq_vector_num_in;
    logic guest_active_out, paged_real_out, inject_out, inject_push_err_out, bypass_intercept_out;
    logic undefined_opcode_fault_out, guest_exit_out, wb_pending_out, wb_shadow_out, phys_irq_take_out;
    logic virt_irq_take_out, prio_rvalid_out, global_irq_gate_out;
    logic [7:0] inject_vector_out, exit_code_out, virt_irq_vector_out;
    logic [2:0] inject_type_out;
    logic [31:0] inject_err_out, ew;
    logic [3:0] wb_virt_task_priority_out, phys_task_priority_out, prio_rdata_out;
    int i, ptpr, vtpr, err_count = 0, comparisons = 0;
    logic [2:0] t;
    logic [7:0] vec, code;
    bit ev, v, bad, hc, g, ep, pt, vt, win, se, sh;

    vei_core DUT (.*);

    initial begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task step;
        @(posedge clk_in);
        #1;
    endtask
    task automatic pulse(ref bit s);
        s = 1;
        step;
        s = 0;
    endtask
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cr_op(input bit wr, input bit [3:0] idx, input bit lk, input bit [3:0] d, input bit gst);
        bit hit;
        hit = idx == 4'h8 || (idx == 4'h0 && lk);
        cr_index_in = idx;
        cr_lock_in = lk;
        cr_wdata_in = d;
        if (wr) pulse(cr_wr_in);
        else pulse(cr_rd_in);
        if (!wr) begin
            chk(prio_rvalid_out, hit);
            if (hit) chk(prio_rdata_out, (gst && virt_irq_mask_mode_in) ? vtpr : ptpr);
        end else if (hit) begin
            if (gst) vtpr = d;
            if (!(gst && virt_irq_mask_mode_in)) ptpr = d;
        end
        chk(phys_task_priority_out, ptpr);
    endtask
    task wrap_up;
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst_in = 1;
        void'($urandom(32'hF862));
        repeat (4) @(posedge clk_in);
        #1 sys_rst_in = 0;
        ptpr = 0;
        chk(global_irq_gate_out, 1);
        chk(guest_active_out, 0);
        chk(phys_task_priority_out, 0);
        sec_exc_intercept_in = 1;
        for (i = 0; i < 48; i++) begin
            t = i % 8;
            vec = ((i / 8) % 3 == 0) ? 8'h02 : ((i / 8) % 3 == 1) ? 8'h05 : 8'($urandom % 64);
            ev = $urandom;
            ew = $urandom;
            v = (i % 16) != 15;
            long_mode_in = i >= 24;
            shadow_in = $urandom;
            hcall_intercept_in = (i / 4) % 2;
            {protection_on_in, paging_on_in} = 2'($urandom);
            event_inject_descriptor_in = {ew, v, 19'h0, ev, t, vec};
            bad = v && (t == 1 || t >= 5 || (t == 3 && (vec >= 8'h20 || vec == 8'h02
                || (vec == 8'h05 && long_mode_in))));
            pulse(entry_in);
            chk(guest_exit_out, bad);
            chk(inject_out, v && !bad);
            chk(guest_active_out, !bad);
            if (bad) chk(exit_code_out, `VEI_EXIT_INVALID);
            if (bad) step;
            if (v && !bad) begin
                chk(bypass_intercept_out, 1);
                chk(inject_vector_out, (t == 2) ? 0 : vec);
                chk(inject_type_out, t);
                chk(inject_push_err_out, ev);
                chk(inject_err_out, ev ? ew : 0);
            end
            if (!bad) begin
                chk(paged_real_out, !protection_on_in && paging_on_in);
                hc = (i % 3 == 0) && hcall_intercept_in;
                if (i % 3 == 0) begin
                    if (v) step;
                    pulse(hypervisor_call_insn_in);
                    chk(undefined_opcode_fault_out, !hc);
                    chk(guest_exit_out, hc);
                    if (hc) chk(exit_code_out, `VEI_EXIT_HCALL);
                end
                if (!hc) begin
                    if (i % 2) pulse(sec_exc_in);
                    else pulse(host_exit_in);
                    code = (i % 2) ? `VEI_EXIT_EXC : `VEI_EXIT_HOST;
                    chk(guest_exit_out, 1);
                    chk(exit_code_out, code);
                end
                chk(wb_shadow_out, shadow_in);
                chk(guest_active_out, 0);
            end
        end
        for (i = 0; i < 40; i++) begin
            g = $urandom;
            if (g) pulse(gate_set_in);
            else pulse(gate_clr_in);
            chk(global_irq_gate_out, g);
            cr_op(1, ($urandom % 2) ? 4'h8 : 4'h0, $urandom, 4'($urandom), 0);
            {virt_irq_mask_mode_in, virt_irq_pending_in, virt_priority_bypass_in, shadow_in} = 4'($urandom);
            {virt_irq_window_in, host_irq_enable_in, irq_enable_flag_in, phys_irq_pending_in} = 4'($urandom);
            {virt_task_priority_in, virt_irq_priority_in, phys_irq_priority_in} = 12'($urandom);
            virt_irq_vector_num_in = $urandom;
            event_inject_descriptor_in = 64'h0;
            vtpr = virt_task_priority_in;
            pulse(entry_in);
            cr_op(1, ($urandom % 2) ? 4'h8 : 4'h0, $urandom, 4'($urandom), 1);
            cr_op(0, ($urandom % 2) ? 4'h8 : 4'h0, $urandom, 4'h0, 1);
            se = $urandom;
            if (se) pulse(set_irq_enable_insn_in);
            sh = shadow_in || (se && !irq_enable_flag_in);
            pulse(boundary_in);
            ep = virt_irq_mask_mode_in ? host_irq_enable_in : irq_enable_flag_in;
            pt = phys_irq_pending_in && g && ep && phys_irq_priority_in > ptpr && !sh;
            vt = virt_irq_pending_in && irq_enable_flag_in && g && !sh && !pt
                && (virt_priority_bypass_in || virt_irq_priority_in > vtpr);
            win = vt && virt_irq_window_in;
            chk(phys_irq_take_out, pt);
            chk(virt_irq_take_out, vt && !win);
            chk(guest_exit_out, win);
            if (vt && !win) chk(virt_irq_vector_out, virt_irq_vector_num_in);
            if (win) chk(exit_code_out, `VEI_EXIT_VIRQ_WIN);
            else pulse(host_exit_in);
            chk(wb_pending_out, virt_irq_pending_in && !(vt && !win));
            chk(wb_virt_task_priority_out, vtpr);
        end
        wrap_up;
    end
endmodule // virtual_event_injection_bench
